// file: shared/mbtc_pkg.sv
// Constants shared by the masked BCD time comparator.
// Assumes one scan clock domain; no bus, registers reached by index.
`default_nettype none
package mbtc_pkg;
  // Operation select
  localparam logic [1:0] OP_TIME = 2'h0;
  localparam logic [1:0] OP_WORD = 2'h1;
  localparam logic [1:0] OP_WORD_REFRESH = 2'h2;
  // Logic form of a time compare
  localparam logic [1:0] FORM_LOAD = 2'h0;
  localparam logic [1:0] FORM_AND = 2'h1;
  localparam logic [1:0] FORM_OR = 2'h2;
  // Function codes of the six time relations
  localparam logic [9:0] FC_EQ = 10'd341;
  localparam logic [9:0] FC_NE = 10'd342;
  localparam logic [9:0] FC_LT = 10'd343;
  localparam logic [9:0] FC_LE = 10'd344;
  localparam logic [9:0] FC_GT = 10'd345;
  localparam logic [9:0] FC_GE = 10'd346;
  // Field geometry
  localparam int FIELD_W = 8;
  localparam int WORD_W = 16;
  localparam int NUM_FIELDS = 6;
  localparam int NUM_WORDS = 3;
  localparam logic [5:0] MASK_ALL = 6'h3f;
  // Field positions in the mask word and in the 48-bit time image
  localparam int FLD_SEC = 0;
  localparam int FLD_MIN = 1;
  localparam int FLD_HOUR = 2;
  localparam int FLD_DAY = 3;
  localparam int FLD_MONTH = 4;
  localparam int FLD_YEAR = 5;
  // Flag positions
  localparam int FLG_EQ = 0;
  localparam int FLG_NE = 1;
  localparam int FLG_LT = 2;
  localparam int FLG_LE = 3;
  localparam int FLG_GT = 4;
  localparam int FLG_GE = 5;
  // Calendar word indices and reset values
  localparam logic [1:0] CAL_IDX_SEC_MIN = 2'h0;
  localparam logic [1:0] CAL_IDX_HOUR_DAY = 2'h1;
  localparam logic [1:0] CAL_IDX_MON_YEAR = 2'h2;
  localparam logic [15:0] CAL_RST_SEC_MIN = 16'h0000;
  localparam logic [15:0] CAL_RST_HOUR_DAY = 16'h0100;
  localparam logic [15:0] CAL_RST_MON_YEAR = 16'h0001;
  // Flag patterns for equal, greater and less outcomes
  localparam logic [5:0] FLAGS_EQ = 6'h29;
  localparam logic [5:0] FLAGS_GT = 6'h32;
  localparam logic [5:0] FLAGS_LT = 6'h0e;
endpackage : mbtc_pkg
`default_nettype wire

// file: src/mbtc_comparator.sv
// Masked BCD time comparator with unsigned one-word compare.
// Assumes instruction strobes come from logic on ref_clk; ext_in_word is a pin.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Time compare drives condition when relation holds
// - Mask bits 0-5: sec,min,hour,day,month,year
// - Mask bit 1 excludes field, 0 includes
// - All masked: no execute, condition off, fault
// - Fields are bytes, low byte less significant
// - Words: sec/min, hour/day, month/year, BCD
// - Six relational flags set from outcome
// - Six relations, codes 341 up, three forms
// - Load starts, and/or combine preceding condition
// - Calendar select uses internal calendar words
// - Word compare: unsigned 16-bit, flags only
// - Word flags follow unsigned first-vs-second order
// - Word compare runs each enabled cycle
// - Refresh variant samples external word first
module mbtc_comparator
  import mbtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [1:0] instr_op,
  input wire logic [9:0] time_func_code,
  input wire logic [1:0] time_form,
  input wire logic cond_in,
  input wire logic [15:0] mask_ctrl,
  input wire logic use_calendar,
  input wire logic [15:0] present_w0,
  input wire logic [15:0] present_w1,
  input wire logic [15:0] present_w2,
  input wire logic [15:0] reference_w0,
  input wire logic [15:0] reference_w1,
  input wire logic [15:0] reference_w2,
  input wire logic [15:0] word_a,
  input wire logic [15:0] word_b,
  input wire logic a_is_ext,
  input wire logic b_is_ext,
  input wire logic [15:0] ext_in_word,
  input wire logic io_refresh,
  input wire logic cal_wr,
  input wire logic [1:0] cal_idx,
  input wire logic [15:0] cal_wdata,
  output logic exec_cond,
  output logic fault_flag,
  output logic eq_flag,
  output logic ne_flag,
  output logic lt_flag,
  output logic le_flag,
  output logic gt_flag,
  output logic ge_flag,
  output logic done,
  output logic [15:0] calendar_seconds_minutes,
  output logic [15:0] calendar_hour_day,
  output logic [15:0] calendar_month_year
);

  logic [15:0] ext_sync1_reg;
  logic [15:0] ext_sync2_reg;
  logic [15:0] ext_image_reg;
  logic [15:0] cal_reg [NUM_WORDS];
  logic exec_reg;
  logic exec_next;
  logic fault_reg;
  logic fault_next;
  logic [5:0] flag_reg;
  logic [5:0] flag_next;
  logic done_reg;

  // External input word, two flops before use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync1_reg <= 16'h0000;
      ext_sync2_reg <= 16'h0000;
    end else begin
      ext_sync1_reg <= ext_in_word;
      ext_sync2_reg <= ext_sync1_reg;
    end
  end

  wire is_time = instr_valid && (instr_op == OP_TIME);
  wire is_word = instr_valid && (instr_op == OP_WORD);
  wire is_wref = instr_valid && (instr_op == OP_WORD_REFRESH);

  // Input image: scan refresh or a refreshed compare with an external operand loads it
  wire img_load = io_refresh || (is_wref && (a_is_ext || b_is_ext));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_image_reg <= 16'h0000;
    end else if (img_load) begin
      ext_image_reg <= ext_sync2_reg;
    end
  end

  // Calendar words, written by the calendar set instruction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_reg[CAL_IDX_SEC_MIN] <= CAL_RST_SEC_MIN;
      cal_reg[CAL_IDX_HOUR_DAY] <= CAL_RST_HOUR_DAY;
      cal_reg[CAL_IDX_MON_YEAR] <= CAL_RST_MON_YEAR;
    end else if (cal_wr && (cal_idx <= CAL_IDX_MON_YEAR)) begin
      cal_reg[cal_idx] <= cal_wdata;
    end
  end

  // Present time from calendar or operand words
  wire [47:0] pres_img = use_calendar ?
    {cal_reg[CAL_IDX_MON_YEAR], cal_reg[CAL_IDX_HOUR_DAY], cal_reg[CAL_IDX_SEC_MIN]} :
    {present_w2, present_w1, present_w0};
  wire [47:0] refr_img = {reference_w2, reference_w1, reference_w0};
  wire [5:0] mask = mask_ctrl[NUM_FIELDS-1:0];
  wire all_masked = (mask == MASK_ALL);

  // Per-field byte compare, low byte is the less significant field
  logic [5:0] fld_ne;
  logic [5:0] fld_gt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FIELDS; gi++) begin : g_field
      wire [7:0] p_b = pres_img[FIELD_W*gi +: FIELD_W];
      wire [7:0] r_b = refr_img[FIELD_W*gi +: FIELD_W];
      assign fld_ne[gi] = !mask[gi] && (p_b != r_b);
      assign fld_gt[gi] = p_b > r_b;
    end
  endgenerate

  // Most significant differing unmasked field decides
  logic t_gt;
  always_comb begin
    t_gt = 1'b0;
    for (int i = 0; i < NUM_FIELDS; i++) begin
      if (fld_ne[i]) begin
        t_gt = fld_gt[i];
      end
    end
  end
  wire t_eq = (fld_ne == 6'h00);
  wire [5:0] t_flags = t_eq ? FLAGS_EQ : (t_gt ? FLAGS_GT : FLAGS_LT);

  // Relation selected by function code
  wire rel_hit =
    ((time_func_code == FC_EQ) && t_flags[FLG_EQ]) ||
    ((time_func_code == FC_NE) && t_flags[FLG_NE]) ||
    ((time_func_code == FC_LT) && t_flags[FLG_LT]) ||
    ((time_func_code == FC_LE) && t_flags[FLG_LE]) ||
    ((time_func_code == FC_GT) && t_flags[FLG_GT]) ||
    ((time_func_code == FC_GE) && t_flags[FLG_GE]);

  // Combine with preceding condition per form
  wire form_res = (time_form == FORM_AND) ? (cond_in && rel_hit) :
                  (time_form == FORM_OR) ? (cond_in || rel_hit) : rel_hit;

  // Unsigned word compare operands
  wire [15:0] ext_val = is_wref ? ext_sync2_reg : ext_image_reg;
  wire [15:0] op_a = a_is_ext ? ext_val : word_a;
  wire [15:0] op_b = b_is_ext ? ext_val : word_b;
  wire [5:0] w_flags = (op_a == op_b) ? FLAGS_EQ :
                       (op_a > op_b) ? FLAGS_GT : FLAGS_LT;

  // Next-state selection
  assign exec_next = is_time ? (!all_masked && form_res) : exec_reg;
  assign fault_next = is_time ? all_masked : fault_reg;
  assign flag_next = (is_time && !all_masked) ? t_flags :
                     (is_word || is_wref) ? w_flags : flag_reg;

  // Result registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_reg <= 1'b0;
      fault_reg <= 1'b0;
      flag_reg <= 6'h00;
      done_reg <= 1'b0;
    end else begin
      exec_reg <= exec_next;
      fault_reg <= fault_next;
      flag_reg <= flag_next;
      done_reg <= instr_valid;
    end
  end

  // Outputs straight from flops
  assign exec_cond = exec_reg;
  assign fault_flag = fault_reg;
  assign eq_flag = flag_reg[FLG_EQ];
  assign ne_flag = flag_reg[FLG_NE];
  assign lt_flag = flag_reg[FLG_LT];
  assign le_flag = flag_reg[FLG_LE];
  assign gt_flag = flag_reg[FLG_GT];
  assign ge_flag = flag_reg[FLG_GE];
  assign done = done_reg;
  assign calendar_seconds_minutes = cal_reg[CAL_IDX_SEC_MIN];
  assign calendar_hour_day = cal_reg[CAL_IDX_HOUR_DAY];
  assign calendar_month_year = cal_reg[CAL_IDX_MON_YEAR];

  // Masked time images, used only by the checks below
  // Unsigned order of these equals the year-first field order
  wire [47:0] keep_bits = {{FIELD_W{!mask[FLD_YEAR]}}, {FIELD_W{!mask[FLD_MONTH]}},
    {FIELD_W{!mask[FLD_DAY]}}, {FIELD_W{!mask[FLD_HOUR]}}, {FIELD_W{!mask[FLD_MIN]}},
    {FIELD_W{!mask[FLD_SEC]}}};
  wire [47:0] pres_kept = pres_img & keep_bits;
  wire [47:0] refr_kept = refr_img & keep_bits;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Checks
  a_fault_all_masked: assert property (is_time |=> (fault_flag == $past(all_masked) &&
    (!$past(all_masked) || !exec_cond))) else $error("fault or condition wrong on full mask");
  a_flags_exclusive: assert property (##1 (eq_flag ^ ne_flag) || (flag_reg == 6'h00))
    else $error("equal and not-equal flags inconsistent");
  a_flags_pattern: assert property ((is_word || is_wref) |=>
    (ge_flag == (gt_flag || eq_flag)) && (le_flag == (lt_flag || eq_flag)))
    else $error("derived flags inconsistent");
  a_word_order: assert property ((is_word || is_wref) |=>
    (gt_flag == ($past(op_a) > $past(op_b))) && (eq_flag == ($past(op_a) == $past(op_b))))
    else $error("word compare order wrong");
  a_mask_ignored: assert property ((is_time && mask[FLD_YEAR] && !all_masked &&
    (pres_img[47:40] != refr_img[47:40]) && (fld_ne[4:0] == 5'h00)) |=> eq_flag)
    else $error("masked year took part in compare");
  a_year_first: assert property ((is_time && fld_ne[FLD_YEAR]) |=>
    (gt_flag == $past(fld_gt[FLD_YEAR]))) else $error("year does not dominate");
  a_and_form: assert property ((is_time && !all_masked && (time_form == FORM_AND) && !cond_in)
    |=> !exec_cond) else $error("and form passed with condition off");
  a_or_form: assert property ((is_time && !all_masked && (time_form == FORM_OR) && cond_in)
    |=> exec_cond) else $error("or form failed with condition on");
  a_eq_relation: assert property ((is_time && !all_masked && (time_form == FORM_LOAD) &&
    (time_func_code == FC_EQ)) |=> (exec_cond == eq_flag)) else $error("equal relation wrong");
  a_word_keeps_cond: assert property ((is_word || is_wref) |=> $stable(exec_cond) &&
    $stable(fault_flag)) else $error("word compare touched condition");
  a_refresh_image: assert property ((is_wref && a_is_ext) |=>
    (ext_image_reg == $past(ext_sync2_reg))) else $error("refresh did not sample input");

  // Time outcome against the masked images
  a_time_equal: assert property ((is_time && !all_masked) |=>
    (eq_flag == $past(pres_kept == refr_kept))) else $error("masked equality wrong");
  a_time_order: assert property ((is_time && !all_masked) |=>
    (gt_flag == $past(pres_kept > refr_kept)) && (lt_flag == $past(pres_kept < refr_kept)))
    else $error("masked time order wrong");
  a_time_derived: assert property ((is_time && !all_masked) |=>
    (ge_flag == !lt_flag) && (le_flag == !gt_flag)) else $error("time derived flags wrong");
  a_fault_clear: assert property ((is_time && !all_masked) |=> !fault_flag)
    else $error("fault left on with a field unmasked");
  a_masked_flags: assert property ((is_time && all_masked) |=> $stable(flag_reg))
    else $error("flags changed by a compare that did not run");

  // Each relation code picks its own flag under the load form; and/or pass it through with a neutral condition
  a_ne_relation: assert property ((is_time && !all_masked && (time_form == FORM_LOAD) &&
    (time_func_code == FC_NE)) |=> (exec_cond == ne_flag))
    else $error("not-equal relation wrong");
  a_lt_relation: assert property ((is_time && !all_masked && (time_form == FORM_LOAD) &&
    (time_func_code == FC_LT)) |=> (exec_cond == lt_flag))
    else $error("less relation wrong");
  a_le_relation: assert property ((is_time && !all_masked && (time_form == FORM_LOAD) &&
    (time_func_code == FC_LE)) |=> (exec_cond == le_flag))
    else $error("less-or-equal relation wrong");
  a_gt_relation: assert property ((is_time && !all_masked && (time_form == FORM_LOAD) &&
    (time_func_code == FC_GT)) |=> (exec_cond == gt_flag))
    else $error("greater relation wrong");
  a_ge_relation: assert property ((is_time && !all_masked && (time_form == FORM_LOAD) &&
    (time_func_code == FC_GE)) |=> (exec_cond == ge_flag))
    else $error("greater-or-equal relation wrong");
  a_and_true: assert property ((is_time && !all_masked && (time_form == FORM_AND) &&
    cond_in && (time_func_code == FC_LT)) |=> (exec_cond == lt_flag))
    else $error("and form lost a true relation");
  a_or_false: assert property ((is_time && !all_masked && (time_form == FORM_OR) &&
    !cond_in && (time_func_code == FC_GE)) |=> (exec_cond == ge_flag))
    else $error("or form changed a lone relation");

  // Remaining word flags against plain unsigned order
  a_word_lt_ne: assert property ((is_word || is_wref) |=>
    (lt_flag == ($past(op_a) < $past(op_b))) && (ne_flag == ($past(op_a) != $past(op_b))))
    else $error("word less or not-equal flag wrong");
  a_word_ge: assert property ((is_word || is_wref) |=>
    (ge_flag == ($past(op_a) >= $past(op_b))) && (le_flag == ($past(op_a) <= $past(op_b))))
    else $error("word or-equal flags wrong");

  // Done follows each instruction by one cycle; a held strobe repeats it
  a_done_pulse: assert property (instr_valid |=> done)
    else $error("done missing after instruction");
  a_done_idle: assert property (!instr_valid |=> !done)
    else $error("done without instruction");

  // Pin word two flops deep; image moves only on a load
  a_sync_two: assert property ($past(rst_n) |=>
    (ext_sync2_reg == $past(ext_in_word, 2))) else $error("pin word not two flops deep");
  a_img_hold: assert property (!img_load |=> $stable(ext_image_reg))
    else $error("input image moved without a load");

  // Calendar words take the written data; the unused index writes nothing
  a_cal_sec_min: assert property ((cal_wr && (cal_idx == CAL_IDX_SEC_MIN)) |=>
    (calendar_seconds_minutes == $past(cal_wdata))) else $error("calendar word 0 not written");
  a_cal_hour_day: assert property ((cal_wr && (cal_idx == CAL_IDX_HOUR_DAY)) |=>
    (calendar_hour_day == $past(cal_wdata))) else $error("calendar word 1 not written");
  a_cal_mon_year: assert property ((cal_wr && (cal_idx == CAL_IDX_MON_YEAR)) |=>
    (calendar_month_year == $past(cal_wdata))) else $error("calendar word 2 not written");
  a_cal_bad_index: assert property ((cal_wr && (cal_idx > CAL_IDX_MON_YEAR)) |=>
    $stable(calendar_seconds_minutes) && $stable(calendar_hour_day) &&
    $stable(calendar_month_year)) else $error("calendar written at unused index");

endmodule : mbtc_comparator
`default_nettype wire

// file: dv/mbtc_ladder_model.sv
// Ladder side of the comparator: rung state and external input pins.
// Assumes the bench sets pin and rung values on the scan clock.
`timescale 1ns/1ps
`default_nettype none
module mbtc_ladder_model (
  input wire logic ref_clk,
  input wire logic [15:0] pin_val,
  input wire logic rung_val,
  output var logic [15:0] ext_in_word,
  output logic cond_in
);
  // Pin word follows the bench value on the clock edge
  always @(posedge ref_clk) begin
    ext_in_word <= pin_val;
  end
  // Preceding rung condition, a plain level
  assign cond_in = rung_val;
endmodule : mbtc_ladder_model
`default_nettype wire

// file: dv/mbtc_comparator_tb_top.sv
// Self-checking bench for the masked BCD time comparator.
// Assumes the ladder model file and the shared package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module mbtc_comparator_tb_top;
  import mbtc_pkg::*;
  logic ref_clk = 0, rst_n = 0, instr_valid = 0, use_calendar = 0, io_refresh = 0, cal_wr = 0;
  logic a_is_ext = 0, b_is_ext = 0, rung = 0, x_ex = 0, x_ft = 0;
  logic [1:0] instr_op = 0, time_form = 0, cal_idx = 0;
  logic [9:0] time_func_code = FC_EQ;
  logic [15:0] mask_ctrl = 0, word_a = 0, word_b = 0, cal_wdata = 0, pin = 0, img = 0;
  logic [47:0] pt = 0, rt = 0;
  logic [15:0] cal [3] = '{CAL_RST_SEC_MIN, CAL_RST_HOUR_DAY, CAL_RST_MON_YEAR};
  logic [5:0] x_fl = 0;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  wire logic exec_cond, fault_flag, eq_flag, ne_flag, lt_flag, le_flag, gt_flag, ge_flag;
  wire logic done, cond_in;
  wire logic [15:0] ext_in_word, calendar_seconds_minutes, calendar_hour_day, calendar_month_year;
  mbtc_comparator mbtc_comparator_inst (.ref_clk, .rst_n, .instr_valid, .instr_op,
    .time_func_code, .time_form, .cond_in, .mask_ctrl, .use_calendar, .present_w0(pt[15:0]),
    .present_w1(pt[31:16]), .present_w2(pt[47:32]), .reference_w0(rt[15:0]),
    .reference_w1(rt[31:16]), .reference_w2(rt[47:32]), .word_a, .word_b, .a_is_ext,
    .b_is_ext, .ext_in_word, .io_refresh, .cal_wr, .cal_idx, .cal_wdata, .exec_cond,
    .fault_flag, .eq_flag, .ne_flag, .lt_flag, .le_flag, .gt_flag, .ge_flag, .done,
    .calendar_seconds_minutes, .calendar_hour_day, .calendar_month_year);
  mbtc_ladder_model mbtc_ladder_model_inst (.ref_clk, .pin_val(pin), .rung_val(rung),
    .ext_in_word, .cond_in);
  // Scan clock, 40 ns
  initial forever #20 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Flag vector for a sign of comparison
  function automatic logic [5:0] fl(input int s);
    return {s >= 0, s > 0, s <= 0, s < 0, s != 0, s == 0};
  endfunction : fl
  // Year down to seconds, unmasked bytes only
  function automatic int tcmp(input logic [47:0] a, input logic [47:0] b, input logic [5:0] m);
    for (int i = 5; i >= 0; i--)
      if (!m[i] && a[i*8+:8] != b[i*8+:8]) return (a[i*8+:8] > b[i*8+:8]) ? 1 : -1;
    return 0;
  endfunction : tcmp
  // Relation chosen by function code
  function automatic logic rel(input logic [9:0] c, input int s);
    return (c == FC_EQ && s == 0) || (c == FC_NE && s != 0) || (c == FC_LT && s < 0) ||
      (c == FC_LE && s <= 0) || (c == FC_GT && s > 0) || (c == FC_GE && s >= 0);
  endfunction : rel
  task automatic chk_cal();
    `CHK("cal0", cal[0], calendar_seconds_minutes)
    `CHK("cal1", cal[1], calendar_hour_day)
    `CHK("cal2", cal[2], calendar_month_year)
  endtask : chk_cal
  // Reset pulse, then every output against its reset value
  task automatic reset_check();
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    cal = '{CAL_RST_SEC_MIN, CAL_RST_HOUR_DAY, CAL_RST_MON_YEAR};
    x_fl = 6'h00;
    x_ex = 1'b0;
    x_ft = 1'b0;
    chk_cal();
    `CHK("rst flags", x_fl, {ge_flag, gt_flag, le_flag, lt_flag, ne_flag, eq_flag})
    `CHK("rst exec", x_ex, exec_cond)
    `CHK("rst fault", x_ft, fault_flag)
    `CHK("rst done", 1'b0, done)
    $display("test reset done");
  endtask : reset_check
  // One instruction, then compare all results
  task automatic run(input logic [1:0] o);
    int s;
    logic [15:0] a;
    logic [15:0] b;
    logic [47:0] pv;
    instr_valid <= 1'b1;
    instr_op <= o;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    if (o == OP_TIME) begin
      pv = use_calendar ? {cal[2], cal[1], cal[0]} : pt;
      s = tcmp(pv, rt, mask_ctrl[5:0]);
      x_ft = (mask_ctrl[5:0] == MASK_ALL);
      if (x_ft) x_ex = 1'b0;
      else begin
        x_fl = fl(s);
        x_ex = rel(time_func_code, s);
        if (time_form == FORM_AND) x_ex = x_ex & cond_in;
        if (time_form == FORM_OR) x_ex = x_ex | cond_in;
      end
    end else begin
      a = a_is_ext ? ((o == OP_WORD_REFRESH) ? pin : img) : word_a;
      b = b_is_ext ? ((o == OP_WORD_REFRESH) ? pin : img) : word_b;
      if ((o == OP_WORD_REFRESH) && (a_is_ext || b_is_ext)) img = pin;
      x_fl = fl(a > b ? 1 : (a < b ? -1 : 0));
    end
    `CHK("flags", x_fl, {ge_flag, gt_flag, le_flag, lt_flag, ne_flag, eq_flag})
    `CHK("exec", x_ex, exec_cond)
    `CHK("fault", x_ft, fault_flag)
    `CHK("done", 1'b1, done)
  endtask : run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    logic [47:0] v;
    void'($urandom(55570));
    reset_check();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      v = 48'($urandom);
      cal_wr <= 1'b1;
      cal_idx <= i[1:0];
      cal_wdata <= v[15:0];
      @(posedge ref_clk);
      cal_wr <= 1'b0;
      if (i < 3) cal[i] = v[15:0];
      #1;
      chk_cal();
    end
    $display("test calendar done");
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      v = 48'({$urandom, $urandom});
      pt <= v;
      rt <= v ^ 48'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom});
      time_func_code <= FC_EQ + 10'($urandom % 7);
      time_form <= 2'($urandom);
      rung <= 1'($urandom);
      mask_ctrl <= ($urandom % 4 == 0) ? (16'($urandom) | 16'h003f) : 16'($urandom);
      use_calendar <= 1'($urandom);
      run(OP_TIME);
    end
    $display("test time compare done");
    @(posedge ref_clk);
    reset_check();
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      pin <= 16'($urandom);
      repeat (4) @(posedge ref_clk);
      io_refresh <= (k == 0);
      @(posedge ref_clk);
      io_refresh <= 1'b0;
      if (k == 0) img = pin;
      for (int i = 0; i < 60; i++) begin
        @(posedge ref_clk);
        word_a <= 16'($urandom);
        word_b <= ($urandom % 3 == 0) ? pin : 16'($urandom);
        a_is_ext <= 1'($urandom);
        b_is_ext <= ($urandom % 4 == 0);
        run(($urandom % 2) ? OP_WORD : OP_WORD_REFRESH);
      end
    end
    $display("test word compare done");
    complete_run();
  end
endmodule : mbtc_comparator_tb_top
`default_nettype wire
